/* pkg/irq_wake_pkg.sv */
// Constants and carrier types for the serial port interrupt and pin wake-up control.
// Assumes a single port-side clock and synchronous, active-high reset.
package irq_wake_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Control bit positions within the interrupt enable field
   localparam int unsigned RX_IRQ_EN_BIT      = 2;
   localparam int unsigned TX_IDLE_IRQ_EN_BIT = 1;
   localparam int unsigned TX_EMPTY_IRQ_EN_BIT = 0;
   localparam int unsigned IRQ_EN_WIDTH       = 3;

   ////////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic       WAKE_REQ_RST  = 1'b0;
   localparam logic       WAKE_IRQ_RST  = 1'b0;
   localparam logic       IRQ_REQ_RST   = 1'b0;
   // Line idles high, so a pin low at reset release counts as a falling edge
   localparam logic       PIN_IDLE_RST  = 1'b1;
   localparam logic [3:0] FLAGS_RST     = 4'h0;
   localparam int unsigned EDGE_WIDTH   = 5;

   ////////////////////////////////////////////////////////////////////////////////
   // Carriers
   typedef struct packed {
      logic rx_irq_enable;        // position RX_IRQ_EN_BIT
      logic tx_idle_irq_enable;   // position TX_IDLE_IRQ_EN_BIT
      logic tx_empty_irq_enable;  // position TX_EMPTY_IRQ_EN_BIT
   } irq_ctrl_t;

   typedef struct packed {
      logic rx_overrun_flag;
      logic rx_data_avail_flag;
      logic tx_idle_flag;
      logic tx_empty_flag;
   } status_flags_t;

endpackage : irq_wake_pkg

/* rtl/edge_detect.sv */
// Edge detector over a vector of synchronous levels; each level is compared with its registered previous value.
// Assumes inputs are already synchronous to clk_i.
`timescale 1ns/1ps
module edge_detect #(
   parameter int unsigned           W       = 1,
   parameter logic [W-1:0]          RST_VAL = '0
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] level_i,
   output logic      [W-1:0] rise_o,
   output logic      [W-1:0] fall_o
);

   logic [W-1:0] prev_reg;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev_reg <= RST_VAL;
      end else begin
         prev_reg <= level_i;
      end
   end

   assign rise_o = level_i & ~prev_reg;
   assign fall_o = ~level_i & prev_reg;

endmodule : edge_detect

/* rtl/uart_irq_wake_control.sv */
// Interrupt enable routing and pin wake-up request for the serial port.
// Assumes all inputs synchronous to mclk_i; the port clock gate is seen as a level.
//
// Behaviour
// - Port clock off and wake enabled: falling pin edge raises a wake-up request.
// - While the port clock runs, pin edges never raise a wake-up request.
// - Wake-up request with its interrupt enabled produces the wake-up interrupt.
// - Wake enable at zero: pin falling edges produce no wake-up request.
// - Receiver enable set: overrun or data-available rising sets the interrupt flag.
// - Receiver enable clear: overrun and data-available do not touch the flag.
// - Idle enable set: transmitter idle flag rising sets the interrupt flag.
// - Idle enable clear: transmitter idle flag does not touch the flag.
// - Bit 0 enables the transmitter empty interrupt source.
// - Empty enable set: transmitter empty flag rising sets the interrupt flag.
`timescale 1ns/1ps
module uart_irq_wake_control
   import irq_wake_pkg::*;
(
   input  wire logic          mclk_i,
   input  wire logic          rst_i,
   input  wire logic          rxtx_pin_i,
   input  wire logic          port_clock_on_i,
   input  wire logic          wake_enable_i,
   input  wire logic          wake_irq_enable_i,
   input  wire logic          wake_req_clr_i,
   input  wire irq_ctrl_t     irq_ctrl_i,
   input  wire status_flags_t status_flags_i,
   input  wire logic          irq_req_clr_i,
   output logic               wake_req_o,
   output logic               wake_irq_o,
   output logic               irq_req_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // Edge detection on the pin and the four status flags

   logic [EDGE_WIDTH-1:0] level_vec;
   logic [EDGE_WIDTH-1:0] rise_vec;
   logic [EDGE_WIDTH-1:0] fall_vec;
   logic                  pin_fall;
   logic                  rise_overrun;
   logic                  rise_avail;
   logic                  rise_idle;
   logic                  rise_empty;

   assign level_vec = {rxtx_pin_i, status_flags_i};

   edge_detect #(
      .W       (EDGE_WIDTH),
      .RST_VAL ({PIN_IDLE_RST, FLAGS_RST})
   ) u_edges (
      .clk_i   (mclk_i),
      .rst_i   (rst_i),
      .level_i (level_vec),
      .rise_o  (rise_vec),
      .fall_o  (fall_vec)
   );

   assign pin_fall     = fall_vec[4];
   assign rise_overrun = rise_vec[3];
   assign rise_avail   = rise_vec[2];
   assign rise_idle    = rise_vec[1];
   assign rise_empty   = rise_vec[0];

   ////////////////////////////////////////////////////////////////////////////////
   // Pin wake-up request

   logic wake_hit;
   logic wake_reg;
   logic wake_next;
   logic wake_irq_reg;

   // Only meaningful with the port clock stopped; a running clock masks it
   assign wake_hit  = pin_fall && !port_clock_on_i && wake_enable_i;
   // Set wins over clear so an edge in the clearing cycle is kept
   assign wake_next = wake_hit || (wake_reg && !wake_req_clr_i);

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         wake_reg <= WAKE_REQ_RST;
      end else begin
         wake_reg <= wake_next;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         wake_irq_reg <= WAKE_IRQ_RST;
      end else begin
         wake_irq_reg <= wake_next && wake_irq_enable_i;
      end
   end

   assign wake_req_o = wake_reg;
   assign wake_irq_o = wake_irq_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Port interrupt request flag

   logic hit_rx;
   logic hit_idle;
   logic hit_empty;
   logic hit_any;
   logic irq_reg;

   assign hit_rx    = irq_ctrl_i.rx_irq_enable && (rise_overrun || rise_avail);
   assign hit_idle  = irq_ctrl_i.tx_idle_irq_enable && rise_idle;
   assign hit_empty = irq_ctrl_i.tx_empty_irq_enable && rise_empty;
   assign hit_any   = hit_rx || hit_idle || hit_empty;

   // Sticky until software clears it; a new event in the clear cycle wins
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         irq_reg <= IRQ_REQ_RST;
      end else begin
         irq_reg <= hit_any || (irq_reg && !irq_req_clr_i);
      end
   end

   assign irq_req_o = irq_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (rst_i);

   wake_on_edge_a: assert property (
      pin_fall && !port_clock_on_i && wake_enable_i |=> wake_req_o)
      else $error("wake request missing after pin falling edge");

   wake_clock_run_a: assert property (
      $rose(wake_req_o) |-> $past(!port_clock_on_i))
      else $error("wake request raised while port clock running");

   wake_irq_fire_a: assert property (
      wake_req_o && $past(wake_irq_enable_i) |-> wake_irq_o)
      else $error("wake interrupt missing with request and enable");

   wake_irq_cause_a: assert property (
      wake_irq_o |-> wake_req_o && $past(wake_irq_enable_i))
      else $error("wake interrupt without request or enable");

   wake_disabled_a: assert property (
      $rose(wake_req_o) |-> $past(wake_enable_i) && $past(pin_fall))
      else $error("wake request raised with wake disabled or no edge");

   wake_hold_a: assert property (
      wake_req_o && !wake_req_clr_i |=> wake_req_o [*1])
      else $error("wake request dropped without clear");

   rx_set_a: assert property (
      irq_ctrl_i.rx_irq_enable && $rose(status_flags_i.rx_overrun_flag) |=> irq_req_o)
      else $error("receiver overrun did not set interrupt flag");

   rx_avail_set_a: assert property (
      irq_ctrl_i.rx_irq_enable && $rose(status_flags_i.rx_data_avail_flag) |=> irq_req_o)
      else $error("receive data available did not set interrupt flag");

   rx_masked_a: assert property (
      !irq_req_o && !irq_ctrl_i.rx_irq_enable && !hit_idle && !hit_empty |=> !irq_req_o)
      else $error("masked receiver source set interrupt flag");

   idle_set_a: assert property (
      irq_ctrl_i.tx_idle_irq_enable && $rose(status_flags_i.tx_idle_flag) |=> irq_req_o)
      else $error("transmitter idle did not set interrupt flag");

   idle_masked_a: assert property (
      !irq_req_o && !irq_ctrl_i.tx_idle_irq_enable && !hit_rx && !hit_empty |=> !irq_req_o)
      else $error("masked idle source set interrupt flag");

   empty_masked_a: assert property (
      !irq_req_o && !irq_ctrl_i.tx_empty_irq_enable && !hit_rx && !hit_idle |=> !irq_req_o)
      else $error("masked empty source set interrupt flag");

   empty_set_a: assert property (
      irq_ctrl_i.tx_empty_irq_enable && $rose(status_flags_i.tx_empty_flag) |=> irq_req_o)
      else $error("transmitter empty did not set interrupt flag");

   irq_or_set_a: assert property (
      hit_any && irq_req_clr_i |=> irq_req_o)
      else $error("clear lost a simultaneous interrupt event");

   irq_cause_a: assert property (
      $rose(irq_req_o) |-> $past(hit_rx || hit_idle || hit_empty))
      else $error("interrupt flag set without enabled source");

   irq_clear_a: assert property (
      irq_req_o && irq_req_clr_i && !hit_any |=> !irq_req_o ##1 (!irq_req_o || $past(hit_any)))
      else $error("interrupt flag not cleared");

   wake_seen_c: cover property (
      !port_clock_on_i && wake_enable_i && pin_fall ##1 wake_req_o ##1 wake_irq_o);

   rx_irq_c: cover property (
      irq_ctrl_i.rx_irq_enable && rise_avail ##1 irq_req_o ##[1:4] irq_req_clr_i);

   empty_irq_c: cover property (hit_empty && hit_idle ##1 irq_req_o);

   wake_blocked_c: cover property (port_clock_on_i && pin_fall && wake_enable_i);

endmodule : uart_irq_wake_control

/* tb/serial_far_end.sv */
// Far-end serial device that drives the shared receive/transmit line.
// Assumes a pull-up on the line, so it idles high whenever released.
`timescale 1ns/1ps
module serial_far_end (
   input  wire logic mclk_i,
   output logic      pin_o
);
   initial pin_o = 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   // Start bit: pull low for a few cycles, then release back to the pull-up
   task automatic send_start(input int cycles);
      @(posedge mclk_i);
      #1 pin_o = 1'b0;
      repeat (cycles) @(posedge mclk_i);
      #1 pin_o = 1'b1;
   endtask : send_start
endmodule : serial_far_end

/* tb/test_uart_irq_wake_control.sv */
// Self-checking bench for the interrupt routing and pin wake-up block.
// Assumes the far end model drives the pin; all other inputs come from here.
`timescale 1ns/1ps
module test_uart_irq_wake_control;
   import irq_wake_pkg::*;

   logic          mclk_i = 1'b0;
   logic          rst_i = 1'b1;
   logic          rxtx_pin;
   logic          port_clock_on = 1'b0;
   logic          wake_enable = 1'b0;
   logic          wake_irq_enable = 1'b0;
   logic          wake_req_clr = 1'b0;
   irq_ctrl_t     irq_ctrl = '0;
   status_flags_t status_flags = '0;
   logic          irq_req_clr = 1'b0;
   logic          wake_req, wake_irq, irq_req;
   int            num_errors = 0;
   int            compares = 0;

   always #50 mclk_i = ~mclk_i;

   serial_far_end far_u (.mclk_i(mclk_i), .pin_o(rxtx_pin));

   uart_irq_wake_control dut_u (
      .mclk_i(mclk_i), .rst_i(rst_i), .rxtx_pin_i(rxtx_pin),
      .port_clock_on_i(port_clock_on), .wake_enable_i(wake_enable),
      .wake_irq_enable_i(wake_irq_enable), .wake_req_clr_i(wake_req_clr),
      .irq_ctrl_i(irq_ctrl), .status_flags_i(status_flags),
      .irq_req_clr_i(irq_req_clr), .wake_req_o(wake_req),
      .wake_irq_o(wake_irq), .irq_req_o(irq_req));

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic seen, input logic exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %b seen %b", name, exp, seen);
      end
   endtask : check

   task automatic close_out();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : close_out

   ////////////////////////////////////////////////////////////////////////////
   // One pin falling edge under given gating, then clear and recheck
   task automatic wake_case(input logic clk_on, input logic wen, input logic ien,
                            input logic exp_req, input logic exp_irq);
      @(posedge mclk_i);
      #1 port_clock_on = clk_on;
      wake_enable = wen;
      wake_irq_enable = ien;
      repeat (2) @(posedge mclk_i);
      far_u.send_start(3);
      repeat (2) @(posedge mclk_i);
      #1;
      check("wake_req", wake_req, exp_req);
      check("wake_irq", wake_irq, exp_irq);
      wake_req_clr = 1'b1;
      @(posedge mclk_i);
      #1 wake_req_clr = 1'b0;
      repeat (2) @(posedge mclk_i);
      #1;
      check("wake_req_clr", wake_req, 1'b0);
      check("wake_irq_clr", wake_irq, 1'b0);
   endtask : wake_case

   // One status flag rises under a given enable set, then clear and recheck
   task automatic flag_case(input int idx, input logic [2:0] en, input logic exp);
      @(posedge mclk_i);
      #1 irq_ctrl = irq_ctrl_t'(en);
      @(posedge mclk_i);
      #1 status_flags = status_flags_t'(4'h1 << idx);
      repeat (3) @(posedge mclk_i);
      #1;
      check("irq_req", irq_req, exp);
      status_flags = '0;
      irq_req_clr = 1'b1;
      @(posedge mclk_i);
      #1 irq_req_clr = 1'b0;
      repeat (2) @(posedge mclk_i);
      #1;
      check("irq_req_clr", irq_req, 1'b0);
   endtask : flag_case

   // Two sources rise together, then a clear meets a new rise: the rise must win
   task automatic irq_race_case();
      @(posedge mclk_i);
      #1 irq_ctrl = irq_ctrl_t'(3'h7);
      status_flags = status_flags_t'(4'h3);
      repeat (2) @(posedge mclk_i);
      #1 irq_req_clr = 1'b1;
      status_flags = status_flags_t'(4'hb);
      @(posedge mclk_i);
      #1 check("irq_req_race", irq_req, 1'b1);
      @(posedge mclk_i);
      #1 irq_req_clr = 1'b0;
      status_flags = '0;
      check("irq_req_race_clr", irq_req, 1'b0);
   endtask : irq_race_case

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge mclk_i);
      #1 rst_i = 1'b0;
      check("irq_rst", irq_req, IRQ_REQ_RST);
      check("wake_rst", wake_req, WAKE_REQ_RST);
      wake_case(1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
      wake_case(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
      wake_case(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
      wake_case(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
      flag_case(3, 3'h4, 1'b1);
      flag_case(2, 3'h4, 1'b1);
      flag_case(3, 3'h3, 1'b0);
      flag_case(2, 3'h3, 1'b0);
      flag_case(1, 3'h2, 1'b1);
      flag_case(1, 3'h5, 1'b0);
      flag_case(0, 3'h1, 1'b1);
      flag_case(0, 3'h6, 1'b0);
      flag_case(1, 3'h7, 1'b1);
      irq_race_case();
      close_out();
   end

   // Whole sequence needs well under 500 cycles
   initial begin
      #(100ns * 3000);
      num_errors++;
      close_out();
   end
endmodule : test_uart_irq_wake_control
